// ---- pkg/mgmt_mem_defines.vh ----
// Behaviour
// R1 - Lower memory of 128 bytes at 00h..7Fh, always reachable.
// R2 - Addressable space is 256 bytes, lower then upper; accesses stay inside.
// R3 - Upper memory 80h..FFh is a window showing one 128-byte page; code maps it to one fixed array, page_reg selects nothing.
// R4 - Unpaged variant: all 256 bytes direct, no page switching.
// R5 - Unpaged variant: content read-only, writes change nothing; code blocks only upper writes, lower registers still take writes.
// R6 - Latch bits are read-only, sticky at one, cleared by host read.
// R7 - Read returns old value, clears afterwards; simultaneous set survives.
// R8 - Each flag pairs with its own mask bit feeding interrupt logic.
// R9 - Host writes masks; a set mask removes that flag's interrupt.
// R10 - Interrupt high while any flag set with mask clear.
// R11 - During access hold-off, host reads and writes are rejected.
// R12 - Freeze holds dynamic registers steady for consistent readout; code holds only last_reg, results and flags still update.
// R13 - On-demand: trigger bit starts one gate period, then idle.
// R14 - Periodic: copy each gate result, restart next gate without gap.
// R15 - Ungated: measure exactly between host start and stop commands.
// R16 - Interval statistics give minimum, maximum and mean per interval.
// R17 - Low/high warning and alarm thresholds each give own indication.
`ifndef MGMT_MEM_DEFINES_VH
`define MGMT_MEM_DEFINES_VH
// Register indices, byte address = index * 4
`define IDX_FLAGS     8'h00
`define IDX_MASK      8'h01
`define IDX_CTRL      8'h02
`define IDX_STAT      8'h03
`define IDX_PAGE      8'h04
`define IDX_THR_LW    8'h05
`define IDX_THR_HW    8'h06
`define IDX_THR_LA    8'h07
`define IDX_THR_HA    8'h08
`define IDX_RES_MIN   8'h09
`define IDX_RES_MAX   8'h0A
`define IDX_RES_AVG   8'h0B
`define IDX_RES_CNT   8'h0C
`define IDX_RES_LAST  8'h0D
`define UPPER_BASE    8'h80
// Control fields
`define CTRL_MODE_LO  0
`define CTRL_MODE_HI  1
`define CTRL_TRIG     2
`define CTRL_START    3
`define CTRL_STOP     4
`define CTRL_FREEZE   5
`define CTRL_FLAT     6
// Flag fields
`define FLG_LW        0
`define FLG_HW        1
`define FLG_LA        2
`define FLG_HA        3
`define FLG_DONE      4
`define FLG_NUM       5
// Modes
`define MODE_OFF      2'h0
`define MODE_DEMAND   2'h1
`define MODE_PERIODIC 2'h2
`define MODE_UNGATED  2'h3
// Gate time in ns and cycles at 10 ns
`define GATE_NS       1000
`define CLK_NS        10
`define GATE_CYC      (`GATE_NS / `CLK_NS)
`define RST_MASK      8'hFF
`define RST_HI_THR    8'hFF
`endif

// ---- rtl/mgmt_mem_flags.v ----
`timescale 1ns/1ps
`include "mgmt_mem_defines.vh"
module mgmt_mem_flags (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire        hold_off,
  input  wire [7:0]  sample,
  input  wire        sample_valid,
  output wire        irq
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [7:0]  flags_reg;
  reg  [7:0]  flags_next;
  reg  [7:0]  seen_reg;
  reg  [7:0]  mask_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  page_reg;
  reg  [7:0]  thr_reg [0:3];
  reg  [7:0]  upper_reg [0:127];
  reg  [7:0]  min_reg;
  reg  [7:0]  max_reg;
  reg  [15:0] sum_reg;
  reg  [7:0]  cnt_reg;
  reg  [7:0]  last_reg;
  reg  [7:0]  res_min_reg;
  reg  [7:0]  res_max_reg;
  reg  [7:0]  res_avg_reg;
  reg  [7:0]  res_cnt_reg;
  reg  [15:0] gate_reg;
  reg         run_reg;
  reg  [31:0] rd_word;
  integer     i;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function is_thr;
    input [7:0] x;
    begin
      is_thr = (x >= `IDX_THR_LW) && (x <= `IDX_THR_HA);
    end
  endfunction

  function [1:0] thr_sel;
    input [7:0] x;
    begin
      thr_sel = x[1:0] - 2'h1;
    end
  endfunction

  function is_upper;
    input [7:0] x;
    begin
      is_upper = (x >= `UPPER_BASE);
    end
  endfunction

  function [7:0] mean8;
    input [15:0] s;
    input [7:0]  n;
    reg   [15:0] q;
    begin
      if (n == 8'h00) begin
        q = 16'h0000;
      end else begin
        q = s / {8'h00, n};
      end
      mean8 = q[7:0];
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire        setup     = psel & ~penable;
  wire        acc       = psel & penable;
  wire        in_range  = (paddr[11:10] == 2'h0) & (paddr[1:0] == 2'h0);
  wire [7:0]  idx       = paddr[9:2];
  wire        reject    = hold_off | ~in_range; // R11 R2
  wire        rd_setup  = setup & ~pwrite & ~reject;
  wire        wr_ok     = acc & pwrite & ~reject & pstrb[0];
  wire        rd_ok     = acc & ~pwrite & ~reject;
  wire        flat      = ctrl_reg[`CTRL_FLAT];
  wire        wr_live   = wr_ok & ~(flat & is_upper(idx)); // R5
  wire [1:0]  mode      = ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
  wire        frozen    = ctrl_reg[`CTRL_FREEZE];

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  wire        wr_ctrl   = wr_live & (idx == `IDX_CTRL);
  wire        rd_flags  = rd_ok & (idx == `IDX_FLAGS);
  wire [31:0] gate_full = `GATE_CYC;
  wire [15:0] gate_load = gate_full[15:0];

  assign pready  = 1'h1;
  assign pslverr = acc & reject; // R11

  // ----------------------------------------
  // Measurement sequencing
  // ----------------------------------------
  wire        gate_end  = run_reg & (mode != `MODE_UNGATED) & (gate_reg == 16'h0001);
  wire        stop_cmd  = wr_ctrl & pwdata[`CTRL_STOP];
  wire        start_cmd = wr_ctrl & pwdata[`CTRL_START];
  wire        trig_cmd  = wr_ctrl & pwdata[`CTRL_TRIG];
  wire        ung_end   = run_reg & (mode == `MODE_UNGATED) & stop_cmd; // R15
  wire        int_end   = gate_end | ung_end;
  wire        take      = run_reg & sample_valid;
  wire        first     = (cnt_reg == 8'h00);
  wire [7:0]  nmin      = (first || sample < min_reg) ? sample : min_reg;
  wire [7:0]  nmax      = (first || sample > max_reg) ? sample : max_reg;
  wire [16:0] sum_wide  = {1'h0, sum_reg} + {9'h000, sample};
  wire [15:0] nsum      = sum_wide[15:0];
  wire [8:0]  cnt_wide  = {1'h0, cnt_reg} + 9'h001;
  wire [7:0]  ncnt      = cnt_wide[7:0];

  // ----------------------------------------
  // Result pick
  // ----------------------------------------
  wire [7:0]  fin_min   = take ? nmin : min_reg;
  wire [7:0]  fin_max   = take ? nmax : max_reg;
  wire [15:0] fin_sum   = take ? nsum : sum_reg;
  wire [7:0]  fin_cnt   = take ? ncnt : cnt_reg;

  // ----------------------------------------
  // Start conditions
  // ----------------------------------------
  wire        go_demand = (mode == `MODE_DEMAND) & trig_cmd; // R13
  wire        go_period = (mode == `MODE_PERIODIC); // R14
  wire        go_ungate = (mode == `MODE_UNGATED) & start_cmd; // R15
  wire        go        = go_demand | go_period | go_ungate;

  // ----------------------------------------
  // Threshold and interval events
  // ----------------------------------------
  wire [7:0] ev;
  assign ev[`FLG_LW]   = sample_valid & (sample < thr_reg[0]); // R17
  assign ev[`FLG_HW]   = sample_valid & (sample > thr_reg[1]); // R17
  assign ev[`FLG_LA]   = sample_valid & (sample < thr_reg[2]); // R17
  assign ev[`FLG_HA]   = sample_valid & (sample > thr_reg[3]); // R17
  assign ev[`FLG_DONE] = int_end;
  assign ev[7:5]       = 3'h0;

  always @* begin
    flags_next = (flags_reg & ~(rd_flags ? seen_reg : 8'h00)) | ev; // R6 R7
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  always @* begin
    rd_word = 32'h0000_0000;
    if (idx == `IDX_FLAGS) begin
      rd_word[7:0] = flags_reg; // R7
    end else if (idx == `IDX_MASK) begin
      rd_word[7:0] = mask_reg;
    end else if (idx == `IDX_CTRL) begin
      rd_word[7:0] = ctrl_reg;
    end else if (idx == `IDX_STAT) begin
      rd_word[1:0] = {run_reg, irq};
    end else if (idx == `IDX_PAGE) begin
      rd_word[7:0] = page_reg;
    end else if (is_thr(idx)) begin
      rd_word[7:0] = thr_reg[thr_sel(idx)];
    end else if (idx == `IDX_RES_MIN) begin
      rd_word[7:0] = res_min_reg;
    end else if (idx == `IDX_RES_MAX) begin
      rd_word[7:0] = res_max_reg;
    end else if (idx == `IDX_RES_AVG) begin
      rd_word[7:0] = res_avg_reg;
    end else if (idx == `IDX_RES_CNT) begin
      rd_word[7:0] = res_cnt_reg;
    end else if (idx == `IDX_RES_LAST) begin
      rd_word[7:0] = last_reg;
    end else if (is_upper(idx)) begin
      rd_word[7:0] = upper_reg[idx[6:0]]; // R3
    end
  end

  // ----------------------------------------
  // Host registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_reg  <= 8'h00;
      seen_reg   <= 8'h00;
      mask_reg   <= `RST_MASK;
      ctrl_reg   <= 8'h00;
      page_reg   <= 8'h00;
      thr_reg[0] <= 8'h00;
      thr_reg[1] <= `RST_HI_THR;
      thr_reg[2] <= 8'h00;
      thr_reg[3] <= `RST_HI_THR;
      for (i = 0; i < 128; i = i + 1) begin
        upper_reg[i] <= 8'h00;
      end
      prdata     <= 32'h0000_0000;
    end else begin
      flags_reg <= flags_next; // R6 R7
      if (rd_setup) begin
        seen_reg <= (idx == `IDX_FLAGS) ? flags_reg : 8'h00;
        prdata   <= rd_word;
      end
      if (wr_live) begin
        if (idx == `IDX_MASK) begin
          mask_reg <= pwdata[7:0]; // R9
        end else if (idx == `IDX_CTRL) begin
          ctrl_reg <= {pwdata[7:5], 3'h0, pwdata[1:0]};
        end else if (idx == `IDX_PAGE) begin
          page_reg <= flat ? 8'h00 : pwdata[7:0]; // R4
        end else if (is_thr(idx)) begin
          thr_reg[thr_sel(idx)] <= pwdata[7:0];
        end else if (is_upper(idx)) begin
          upper_reg[idx[6:0]] <= pwdata[7:0]; // R3
        end
      end
    end
  end

  // ----------------------------------------
  // Gate control
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_reg  <= 1'h0;
      gate_reg <= 16'h0000;
    end else begin
      if (mode == `MODE_OFF) begin
        run_reg <= 1'h0;
      end else if (!run_reg) begin
        if (go) begin // R13 R15
          run_reg  <= 1'h1;
          gate_reg <= gate_load;
        end
      end else if (int_end) begin
        run_reg  <= (mode == `MODE_PERIODIC); // R14 R13
        gate_reg <= gate_load;
      end else if (gate_reg != 16'h0000) begin
        gate_reg <= gate_reg - 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // Interval statistics
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      min_reg     <= 8'h00;
      max_reg     <= 8'h00;
      sum_reg     <= 16'h0000;
      cnt_reg     <= 8'h00;
      res_min_reg <= 8'h00;
      res_max_reg <= 8'h00;
      res_avg_reg <= 8'h00;
      res_cnt_reg <= 8'h00;
    end else begin
      if (int_end) begin
        res_min_reg <= fin_min; // R14 R16
        res_max_reg <= fin_max; // R16
        res_avg_reg <= mean8(fin_sum, fin_cnt); // R16
        res_cnt_reg <= fin_cnt;
        cnt_reg     <= 8'h00;
        sum_reg     <= 16'h0000;
      end else if (take) begin
        min_reg <= nmin;
        max_reg <= nmax;
        sum_reg <= nsum;
        cnt_reg <= ncnt;
      end else if (!run_reg) begin
        cnt_reg <= 8'h00;
        sum_reg <= 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // Live value, held while frozen
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_reg <= 8'h00;
    end else if (sample_valid && !frozen) begin
      last_reg <= sample; // R12
    end
  end

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  assign irq = |(flags_reg & ~mask_reg); // R8 R9 R10

endmodule // mgmt_mem_flags

// ---- tb/mgmt_mem_flags_assertions.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module mgmt_mem_flags_assertions (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        hold_off,
  input wire        irq
);
  wire acc = psel && penable;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_HOLD: assert property (acc && hold_off |-> pslverr)
    else $error("held access not refused");
  AST_RANGE: assert property (acc && paddr >= 12'h400 |-> pslverr)
    else $error("out of range access not refused");
  AST_ALIGN: assert property (acc && paddr[1:0] != 2'h0 |-> pslverr)
    else $error("unaligned access not refused");
  AST_OK: assert property (acc && !hold_off && paddr < 12'h400 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("good access refused");
  AST_ERR_PHASE: assert property (pslverr |-> acc)
    else $error("error outside access phase");
  AST_KEEP: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved without good read");
  AST_UPPER: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_IRQ_RST: assert property ($rose(presetn) |-> !irq)
    else $error("interrupt after reset");
  AST_IRQ_MASK: assert property (acc && pwrite && !pslverr && paddr == 12'h004
    && pwdata[7:0] == 8'hFF |=> !irq)
    else $error("interrupt with all masks set");
endmodule // mgmt_mem_flags_assertions
bind mgmt_mem_flags mgmt_mem_flags_assertions mgmt_mem_flags_assertions_i (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pslverr, .hold_off, .irq);

// ---- tb/host_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// Host side bus master
// ----------------------------------------
module host_model (
  input  wire        pclk,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input  wire        pready,
  input  wire [31:0] prdata,
  input  wire        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q, output logic e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    e = pslverr;
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
endmodule // host_model

// ---- tb/tb_module_mgmt_memory_flags.sv ----
`timescale 1ns/1ps
`include "mgmt_mem_defines.vh"
module tb_module_mgmt_memory_flags;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        hold_off, sample_valid, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0]  pstrb;
  logic [7:0]  sample;
  int          miscompares = 0, total_checks = 0;
  mgmt_mem_flags mgmt_mem_flags_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .hold_off, .sample, .sample_valid, .irq);
  host_model host_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
    .prdata, .pslverr);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task finish_test;
    if (miscompares == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, x, s);
    end
  endtask
  task wr(input logic [7:0] i, input logic [7:0] d);
    host_model_i.xfer(1'b1, {2'b00, i, 2'b00}, {24'h0, d}, q, e);
  endtask
  task rd(input logic [7:0] i, input logic [7:0] x);
    host_model_i.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, q, e);
    chk($sformatf("reg %h", i), q, {24'h0, x});
  endtask
  task smp(input logic [7:0] v);
    sample <= v;
    sample_valid <= 1'b1;
    @(posedge pclk);
    sample_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task bad(input logic w, input logic [11:0] a);
    host_model_i.xfer(w, a, 32'h0, q, e);
    chk("refusal", e, 1);
  endtask
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    #200000;
    miscompares++;
    finish_test;
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    presetn = 0; hold_off = 0; sample = 0; sample_valid = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("irq", irq, 0);
    rd(`IDX_MASK, 8'hFF);
    rd(`IDX_FLAGS, 8'h00);
    wr(`IDX_THR_LW, 8'h0A);
    wr(`IDX_THR_HW, 8'hC8);
    wr(`IDX_THR_LA, 8'h02);
    wr(`IDX_THR_HA, 8'hF0);
    wr(`IDX_MASK, 8'h00);
    smp(8'hFA);
    chk("irq", irq, 1);
    rd(`IDX_FLAGS, 8'h0A);
    rd(`IDX_FLAGS, 8'h00);
    chk("irq", irq, 0);
    smp(8'h01);
    chk("irq", irq, 1);
    wr(`IDX_MASK, 8'h05);
    chk("irq", irq, 0);
    hold_off <= 1'b1;
    bad(1'b0, 12'h000);
    hold_off <= 1'b0;
    bad(1'b0, 12'h400);
    bad(1'b1, 12'h006);
    rd(`IDX_FLAGS, 8'h05);
    wr(8'h80, 8'hA5);
    rd(8'h80, 8'hA5);
    wr(`IDX_CTRL, 8'h40);
    wr(8'h80, 8'h5A);
    rd(8'h80, 8'hA5);
    wr(`IDX_CTRL, 8'h01);
    wr(`IDX_CTRL, 8'h05);
    smp(8'h14);
    smp(8'h28);
    repeat (`GATE_CYC) @(posedge pclk);
    rd(`IDX_FLAGS, 8'h10);
    smp(8'h1E);
    rd(`IDX_RES_MIN, 8'h14);
    rd(`IDX_RES_MAX, 8'h28);
    rd(`IDX_RES_AVG, 8'h1E);
    rd(`IDX_RES_CNT, 8'h02);
    wr(`IDX_CTRL, 8'h03);
    wr(`IDX_CTRL, 8'h0B);
    smp(8'h32);
    smp(8'h3C);
    wr(`IDX_CTRL, 8'h13);
    rd(`IDX_FLAGS, 8'h10);
    rd(`IDX_RES_MIN, 8'h32);
    rd(`IDX_RES_MAX, 8'h3C);
    rd(`IDX_RES_AVG, 8'h37);
    rd(`IDX_RES_CNT, 8'h02);
    wr(`IDX_CTRL, 8'h20);
    smp(8'h77);
    rd(`IDX_RES_LAST, 8'h3C);
    wr(`IDX_CTRL, 8'h00);
    smp(8'h44);
    rd(`IDX_RES_LAST, 8'h44);
    wr(`IDX_CTRL, 8'h02);
    repeat (150) @(posedge pclk);
    chk("irq", irq, 1);
    wr(`IDX_MASK, 8'hFF);
    chk("irq", irq, 0);
    rd(`IDX_STAT, 8'h02);
    rd(`IDX_FLAGS, 8'h10);
    finish_test;
  end
endmodule // tb_module_mgmt_memory_flags
